// File: design/gtm_timer.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "gtm_cfg.svh"
// Function
// - Byte reads of the count see the live counter, with no latch
// - Gated counting only while gate active
// - Polarity bit picks the counting gate level
// - Two-bit field selects gate source
// - Companion timer wrap makes a gate pulse
// - Toggle flip-flop measures full gate period
// - Single pulse arms, counts, clears go
// - Clearing pulse mode clears go bit
// - Gate level status always readable
// - Gate falling edge sets gate flag
// - Counter wraps and sets overflow flag
// - Overflow interrupt needs all enables
// - Sleep counting only with sync bit set and external or temp clock
// - Count is capture and compare time base
// - Special trigger clears count, no flag
// - Software write beats special trigger clear
// - Two-bit field selects counter clock
// - Two-bit prescaler divides input clock
// - Sync bit bypasses external synchroniser
// - Timer-on enables; off clears toggle
module gtm_timer
  import gtm_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata_ff,
  input wire logic external_clock_pin,
  input wire logic temp_osc_in,
  input wire logic gate_input_pin,
  input wire logic comparator_one_synced_out,
  input wire logic comparator_two_synced_out,
  input wire logic [7:0] eight_bit_companion_timer,
  input wire logic sleep_mode,
  input wire logic capture_evt,
  input wire logic special_evt,
  output logic compare_evt_ff,
  output logic irq_req,
  output logic wake_req,
  output logic [15:0] isr_vector
);
  // Software-visible state, next values and internal history flops.
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [7:0] ctrl_ff;
  logic [7:0] gate_ff;
  logic go_ff;
  logic nxt_go;
  logic gflag_ff;
  logic ovf_ff;
  logic gie_en_ff;
  logic ovf_ie_ff;
  logic gie_ff;
  logic peripheral_irq_global_en_ff;
  logic [15:0] ccp_ff;
  logic cmp_en_ff;
  logic match_ff;
  logic gval_prev_ff;
  logic [7:0] t0_prev_ff;
  logic [1:0] idiv_ff;
  logic [7:0] nxt_rdata;

  // Pin sampling for the clock sources.
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic ext_s3_ff;
  logic ext_raw_ff;
  logic ext_raw_d_ff;
  logic tmp_s1_ff;
  logic tmp_s2_ff;
  logic tmp_s3_ff;

  logic gate_val;
  logic go_done;
  logic pre_tick;
  logic src_tick;

  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  // Address decode.
  wire wr_lo = wr_en && (addr == `GTM_A_CNT_LO);
  wire wr_hi = wr_en && (addr == `GTM_A_CNT_HI);
  wire wr_cnt = wr_lo || wr_hi;
  wire wr_ctrl = wr_en && (addr == `GTM_A_CTRL);
  wire wr_gate = wr_en && (addr == `GTM_A_GATE);
  wire wr_pflag = wr_en && (addr == `GTM_A_PFLAG);
  wire wr_pie = wr_en && (addr == `GTM_A_PIE);
  wire wr_irq_control_reg = wr_en && (addr == `GTM_A_IRQ_CONTROL_REG);
  wire wr_ccp_lo = wr_en && (addr == `GTM_A_CCP_LO);
  wire wr_ccp_hi = wr_en && (addr == `GTM_A_CCP_HI);
  wire wr_ccp_ctrl = wr_en && (addr == `GTM_A_CCP_CTRL);

  // Control fields.
  wire timer_on_bit = ctrl_ff[`GTM_ON_BIT];
  wire sync_bypass_bit = ctrl_ff[`GTM_SYNC_BIT];
  wire [1:0] clock_source_field = ctrl_ff[`GTM_CS_HI:`GTM_CS_LO];
  wire [1:0] prescale_field = ctrl_ff[`GTM_PS_HI:`GTM_PS_LO];
  wire gate_enable_bit = gate_ff[`GTM_GE_BIT];
  wire ext_sel = clock_source_field[1];

  // Companion timer wrap from all ones to zero.
  wire companion_ovf = (t0_prev_ff == 8'hff) &&
                       (eight_bit_companion_timer == 8'h00);

  // Bypass samples the pin once; sync adds one more stage.
  wire ext_edge = sync_bypass_bit ? rise(ext_raw_ff, ext_raw_d_ff)
                                  : rise(ext_s2_ff, ext_s3_ff);
  wire tmp_edge = rise(tmp_s2_ff, tmp_s3_ff);
  wire instr_tick = (idiv_ff == `GTM_INSTR_DIV);

  always_comb begin
    case (gtm_clk_src_e'(clock_source_field))
      GTM_CS_TEMP: src_tick = tmp_edge;
      GTM_CS_EXT: src_tick = ext_edge;
      GTM_CS_SYS: src_tick = 1'b1;
      GTM_CS_INSTR: src_tick = instr_tick;
      default: src_tick = 1'b0;
    endcase
  end

  gtm_prescale #(
    .DW(3)
  ) u_pre (
    .clk(clk),
    .rst_n(rst_n),
    .tick_in(src_tick),
    .clear(wr_cnt),
    .ratio(prescale_field),
    .tick_out(pre_tick)
  );

  gtm_gate u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .gate_input_pin(gate_input_pin),
    .cmp1_synced(comparator_one_synced_out),
    .cmp2_synced(comparator_two_synced_out),
    .companion_ovf(companion_ovf),
    .gate_source_select(gate_ff[`GTM_GSS_HI:`GTM_GSS_LO]),
    .gate_polarity_bit(gate_ff[`GTM_POL_BIT]),
    .gate_toggle_enable(gate_ff[`GTM_TM_BIT]),
    .single_pulse_enable(gate_ff[`GTM_SPM_BIT]),
    .pulse_acquire_go(go_ff),
    .timer_on(timer_on_bit),
    .gate_val_ff(gate_val),
    .go_done(go_done)
  );

  // In sleep only the external or temp source with the sync bit set keeps running.
  wire sleep_ok = !sleep_mode || (ext_sel && sync_bypass_bit);
  wire gate_ok = !gate_enable_bit || gate_val;
  wire cnt_en = timer_on_bit && gate_ok && sleep_ok;
  wire inc = cnt_en && pre_tick;
  wire wrap = inc && !wr_cnt && !special_evt && (&cnt_ff);
  wire gate_fall = gval_prev_ff && !gate_val;
  wire match = (ccp_ff == cnt_ff[15:0]);

  // A write wins over the special clear, which wins over counting.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (wr_lo) begin
      nxt_cnt[7:0] = wdata;
    end else if (wr_hi) begin
      nxt_cnt[15:8] = wdata;
    end else if (special_evt) begin
      nxt_cnt = '0;
    end else if (inc) begin
      nxt_cnt = cnt_ff + CW'(1);
    end
  end

  // Go clears when the pulse mode is dropped or the pulse is done.
  always_comb begin
    nxt_go = go_ff;
    if (wr_gate) begin
      nxt_go = wdata[`GTM_GO_BIT];
    end
    if (!gate_ff[`GTM_SPM_BIT] || go_done) begin
      nxt_go = 1'b0;
    end
    if (wr_gate && !wdata[`GTM_SPM_BIT]) begin
      nxt_go = 1'b0;
    end
  end

  always_comb begin
    case (addr)
      `GTM_A_CNT_LO: nxt_rdata = cnt_ff[7:0];
      `GTM_A_CNT_HI: nxt_rdata = cnt_ff[15:8];
      `GTM_A_CTRL: nxt_rdata = ctrl_ff;
      `GTM_A_GATE: nxt_rdata = {gate_ff[7:4], go_ff, gate_val,
                                gate_ff[1:0]};
      `GTM_A_PFLAG: nxt_rdata = {gflag_ff, 6'h00, ovf_ff};
      `GTM_A_PIE: nxt_rdata = {gie_en_ff, 6'h00, ovf_ie_ff};
      `GTM_A_IRQ_CONTROL_REG: nxt_rdata = {gie_ff, peripheral_irq_global_en_ff, 6'h00};
      `GTM_A_CCP_LO: nxt_rdata = ccp_ff[7:0];
      `GTM_A_CCP_HI: nxt_rdata = ccp_ff[15:8];
      `GTM_A_CCP_CTRL: nxt_rdata = {7'h00, cmp_en_ff};
      default: nxt_rdata = `GTM_RST8;
    endcase
  end

  // Pin samplers; each synchroniser first stage feeds only the second, while the bypass sample also feeds the edge detect.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      ext_raw_ff <= 1'b0;
      ext_raw_d_ff <= 1'b0;
      tmp_s1_ff <= 1'b0;
      tmp_s2_ff <= 1'b0;
      tmp_s3_ff <= 1'b0;
    end else begin
      ext_s1_ff <= external_clock_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      ext_raw_ff <= external_clock_pin;
      ext_raw_d_ff <= ext_raw_ff;
      tmp_s1_ff <= temp_osc_in;
      tmp_s2_ff <= tmp_s1_ff;
      tmp_s3_ff <= tmp_s2_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idiv_ff <= 2'h0;
      t0_prev_ff <= `GTM_RST8;
      gval_prev_ff <= 1'b0;
      cnt_ff <= '0;
      go_ff <= 1'b0;
      rdata_ff <= `GTM_RST8;
    end else begin
      idiv_ff <= idiv_ff + 2'h1;
      t0_prev_ff <= eight_bit_companion_timer;
      gval_prev_ff <= gate_val;
      cnt_ff <= nxt_cnt;
      go_ff <= nxt_go;
      rdata_ff <= rd_en ? nxt_rdata : `GTM_RST8;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= `GTM_RST8;
      gate_ff <= `GTM_RST8;
      gie_en_ff <= 1'b0;
      ovf_ie_ff <= 1'b0;
      gie_ff <= 1'b0;
      peripheral_irq_global_en_ff <= 1'b0;
      cmp_en_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wdata & `GTM_CTRL_MASK;
      end
      if (wr_gate) begin
        gate_ff <= wdata;
      end
      if (wr_pie) begin
        gie_en_ff <= wdata[`GTM_GF_BIT];
        ovf_ie_ff <= wdata[`GTM_OVF_BIT];
      end
      if (wr_irq_control_reg) begin
        gie_ff <= wdata[`GTM_GIE_BIT];
        peripheral_irq_global_en_ff <= wdata[`GTM_PERIPHERAL_IRQ_GLOBAL_EN_BIT];
      end
      if (wr_ccp_ctrl) begin
        cmp_en_ff <= wdata[`GTM_CMP_EN_BIT];
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gflag_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      gflag_ff <= gate_fall ||
                  (wr_pflag ? wdata[`GTM_GF_BIT] : gflag_ff);
      ovf_ff <= wrap ||
                (wr_pflag ? wdata[`GTM_OVF_BIT] : ovf_ff);
    end
  end

  // Capture and compare share the pair; software writes win.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ccp_ff <= 16'h0000;
      match_ff <= 1'b0;
      compare_evt_ff <= 1'b0;
    end else begin
      match_ff <= match;
      compare_evt_ff <= cmp_en_ff && rise(match, match_ff);
      if (wr_ccp_lo) begin
        ccp_ff[7:0] <= wdata;
      end else if (wr_ccp_hi) begin
        ccp_ff[15:8] <= wdata;
      end else if (capture_evt && !cmp_en_ff) begin
        ccp_ff <= cnt_ff[15:0];
      end
    end
  end

  // The overflow source also needs the timer switched on.
  wire ovf_src = ovf_ff && ovf_ie_ff && timer_on_bit;
  wire gev_src = gflag_ff && gie_en_ff;
  wire any_src = (ovf_src || gev_src) && peripheral_irq_global_en_ff;
  assign irq_req = any_src && gie_ff;
  assign wake_req = any_src && sleep_mode;
  assign isr_vector = irq_req ? `GTM_ISR_VECTOR : 16'h0000;

  ovf_sets_flag_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      wrap && !wr_cnt && !special_evt |=> ovf_ff && cnt_ff == '0)
    else $error("wrap did not set the overflow flag");

  gate_holds_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      timer_on_bit && gate_enable_bit && !gate_val && !wr_cnt &&
      !special_evt |=> $stable(cnt_ff))
    else $error("count moved while the gate was inactive");

  special_clear_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      special_evt && !wr_cnt && !ovf_ff |=> cnt_ff == '0 && !ovf_ff)
    else $error("special trigger did not clear cleanly");

  write_wins_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      wr_lo && special_evt |=> cnt_ff[7:0] == $past(wdata))
    else $error("special trigger beat a count write");

  go_cleared_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      !gate_ff[`GTM_SPM_BIT] ##1 !gate_ff[`GTM_SPM_BIT] |-> !go_ff)
    else $error("go bit survived with pulse mode off");

  gate_fall_flag_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      $fell(gate_val) |=> gflag_ff)
    else $error("gate falling edge lost its flag");

  timer_off_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      !timer_on_bit && !wr_cnt && !special_evt |=> $stable(cnt_ff))
    else $error("count moved with the timer off");

  read_count_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && addr == `GTM_A_CNT_LO |=> rdata_ff == $past(cnt_ff[7:0]))
    else $error("count low byte read back wrong");

  irq_gated_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      irq_req |-> gie_ff && peripheral_irq_global_en_ff && (gie_en_ff || ovf_ie_ff))
    else $error("interrupt raised without its enables");
endmodule

// File: design/gtm_cfg.svh
`ifndef GTM_CFG_SVH
`define GTM_CFG_SVH

// Register addresses.
`define GTM_A_CNT_LO 4'h0
`define GTM_A_CNT_HI 4'h1
`define GTM_A_CTRL 4'h2
`define GTM_A_GATE 4'h3
`define GTM_A_PFLAG 4'h4
`define GTM_A_PIE 4'h5
`define GTM_A_IRQ_CONTROL_REG 4'h6
`define GTM_A_CCP_LO 4'h7
`define GTM_A_CCP_HI 4'h8
`define GTM_A_CCP_CTRL 4'h9

// Timer control fields.
`define GTM_CS_HI 7
`define GTM_CS_LO 6
`define GTM_PS_HI 5
`define GTM_PS_LO 4
`define GTM_SYNC_BIT 2
`define GTM_ON_BIT 0
`define GTM_CTRL_MASK 8'hf5

// Gate control fields.
`define GTM_GE_BIT 7
`define GTM_POL_BIT 6
`define GTM_TM_BIT 5
`define GTM_SPM_BIT 4
`define GTM_GO_BIT 3
`define GTM_VAL_BIT 2
`define GTM_GSS_HI 1
`define GTM_GSS_LO 0

// Flag, enable and global control fields.
`define GTM_GF_BIT 7
`define GTM_OVF_BIT 0
`define GTM_GIE_BIT 7
`define GTM_PERIPHERAL_IRQ_GLOBAL_EN_BIT 6
`define GTM_CMP_EN_BIT 0

`define GTM_RST8 8'h00
`define GTM_ISR_VECTOR 16'h0004
`define GTM_INSTR_DIV 2'h3

`endif

// File: design/gtm_pkg.sv
package gtm_pkg;
  typedef enum logic [1:0] {
    GTM_CS_INSTR,
    GTM_CS_SYS,
    GTM_CS_EXT,
    GTM_CS_TEMP
  } gtm_clk_src_e;

  typedef enum logic {
    GTM_SP_IDLE,
    GTM_SP_RUN
  } gtm_sp_state_e;
endpackage

// File: design/gtm_prescale.sv
`timescale 1ns/100ps
module gtm_prescale #(
  parameter int DW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [1:0] ratio,
  output logic tick_out
);
  logic [DW-1:0] cnt_ff;
  logic [DW-1:0] nxt_cnt;
  wire [DW-1:0] mask = DW'((1 << ratio) - 1);

  // Divide by 1, 2, 4 or 8.
  assign tick_out = tick_in && ((cnt_ff & mask) == mask);
  assign nxt_cnt = clear ? '0 : (tick_in ? cnt_ff + DW'(1) : cnt_ff);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// File: design/gtm_gate.sv
`timescale 1ns/100ps
module gtm_gate
  import gtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gate_input_pin,
  input wire logic cmp1_synced,
  input wire logic cmp2_synced,
  input wire logic companion_ovf,
  input wire logic [1:0] gate_source_select,
  input wire logic gate_polarity_bit,
  input wire logic gate_toggle_enable,
  input wire logic single_pulse_enable,
  input wire logic pulse_acquire_go,
  input wire logic timer_on,
  output logic gate_val_ff,
  output logic go_done
);
  logic act_ff;
  logic tff_ff;
  logic tg_ff;
  gtm_sp_state_e sp_ff;
  gtm_sp_state_e nxt_sp;
  logic sel;

  always_comb begin
    case (gate_source_select)
      2'h3: sel = cmp2_synced;
      2'h2: sel = cmp1_synced;
      2'h1: sel = companion_ovf;
      default: sel = gate_input_pin;
    endcase
  end

  wire act = gate_polarity_bit ? sel : ~sel;
  wire act_rise = act & ~act_ff;
  wire tg = gate_toggle_enable ? tff_ff : act;
  wire tg_rise = tg & ~tg_ff;

  // Single pulse: arm on a rising edge, finish on the trailing edge.
  always_comb begin
    nxt_sp = sp_ff;
    case (sp_ff)
      GTM_SP_IDLE: begin
        if (single_pulse_enable && pulse_acquire_go && tg_rise) begin
          nxt_sp = GTM_SP_RUN;
        end
      end
      GTM_SP_RUN: begin
        if (!single_pulse_enable || !tg) begin
          nxt_sp = GTM_SP_IDLE;
        end
      end
      default: nxt_sp = GTM_SP_IDLE;
    endcase
  end

  assign go_done = (sp_ff == GTM_SP_RUN) && !tg && single_pulse_enable;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act_ff <= 1'b0;
      tff_ff <= 1'b0;
      tg_ff <= 1'b0;
      sp_ff <= GTM_SP_IDLE;
      gate_val_ff <= 1'b0;
    end else begin
      act_ff <= act;
      tg_ff <= tg;
      sp_ff <= nxt_sp;
      if (!gate_toggle_enable || !timer_on) begin
        tff_ff <= 1'b0;
      end else if (act_rise) begin
        tff_ff <= ~tff_ff;
      end
      gate_val_ff <= single_pulse_enable ? (nxt_sp == GTM_SP_RUN) : tg;
    end
  end
endmodule

// File: testbench/gtm_far_side.sv
`timescale 1ns/100ps
module gtm_far_side (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_run,
  output logic ext_clk,
  output logic temp_osc,
  output logic [7:0] comp_tmr
);
  logic [2:0] div_ff;
  // The pin clock stands still outside a run, as a gated source would.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_ff <= 3'h0;
      ext_clk <= 1'b0;
      temp_osc <= 1'b0;
      comp_tmr <= 8'h00;
    end else begin
      div_ff <= div_ff + 3'h1;
      comp_tmr <= comp_tmr + 8'h01;
      if (ext_run && div_ff[1:0] == 2'h3) begin
        ext_clk <= !ext_clk;
      end
      if (div_ff == 3'h7) begin
        temp_osc <= !temp_osc;
      end
    end
  end
endmodule

// File: testbench/tb_gtm_timer.sv
`timescale 1ns/100ps
`include "gtm_cfg.svh"
module tb_gtm_timer;
  logic clk, rst_n, wr_en, rd_en, pin_g, c1, c2, slp, cap, spe, run;
  logic ext_clk, tosc, cmp, irq, wake;
  logic [3:0] addr;
  logic [7:0] wdata, rdata_ff, ctmr, d;
  logic [15:0] vec, v;
  int n_errors, samples_checked, cyc, i, n_cmp;
  logic [7:0] ctl [8] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01, 8'h81,
                          8'h85, 8'hc1};
  int expc [8] = '{128, 64, 32, 16, 32, 16, 16, 8};
  int q [$];

  gtm_far_side u_far (.clk(clk), .rst_n(rst_n), .ext_run(run),
    .ext_clk(ext_clk), .temp_osc(tosc), .comp_tmr(ctmr));
  gtm_timer u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata_ff(rdata_ff),
    .external_clock_pin(ext_clk), .temp_osc_in(tosc),
    .gate_input_pin(pin_g), .comparator_one_synced_out(c1),
    .comparator_two_synced_out(c2), .eight_bit_companion_timer(ctmr),
    .sleep_mode(slp), .capture_evt(cap), .special_evt(spe),
    .compare_evt_ff(cmp), .irq_req(irq), .wake_req(wake),
    .isr_vector(vec));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // Compare pulses last one cycle, so they are counted as they happen.
  always @(posedge clk) begin
    if (cmp) begin
      n_cmp++;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Counts are judged within a window because the pipeline delay of the
  // clock path is a designer choice and the pin clock has its own phase.
  task automatic span(input string nm, input int e, input logic [7:0] g);
    samples_checked++;
    if ((g >= e - 3 && g <= e + 3) !== 1'b1) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 x = rdata_ff;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    {rst_n, wr_en, rd_en, pin_g, c1, c2, slp, cap, spe, run} = '0;
    addr = 4'h0;
    wdata = 8'h00;
    wt(5);
    rst_n <= 1'b1;
    void'($urandom(32'hc297bcbf));
    rd(`GTM_A_CTRL, d); chk("ctrl", 16'h0, d);
    // Polarity low with the pin low means the gate is active.
    rd(`GTM_A_GATE, d); chk("gate", 16'h4, d);
    rd(`GTM_A_PFLAG, d); chk("pflag", 16'h0, d);
    rd(4'hf, d); chk("unmapped", 16'h0, d);
    wr(`GTM_A_CTRL, 8'hff);
    rd(`GTM_A_CTRL, d); chk("ctrl mask", 16'hf5, d);
    wr(`GTM_A_CTRL, 8'h00);
    $display("register test done");
    repeat (4) begin
      v = 16'($urandom);
      q.push_back(int'(v));
      wr(`GTM_A_CNT_LO, v[7:0]);
      wr(`GTM_A_CNT_HI, v[15:8]);
      rd(`GTM_A_CNT_LO, d); chk("cnt lo", 16'(q[$] & 255), d);
      rd(`GTM_A_CNT_HI, d); chk("cnt hi", 16'(q[$] >> 8), d);
    end
    @(posedge clk) spe <= 1'b1;
    @(posedge clk) spe <= 1'b0;
    rd(`GTM_A_CNT_HI, d); chk("special clr", 16'h0, d);
    rd(`GTM_A_PFLAG, d); chk("special flag", 16'h0, d);
    @(posedge clk);
    spe <= 1'b1;
    addr <= `GTM_A_CNT_LO;
    wdata <= 8'h5a;
    wr_en <= 1'b1;
    @(posedge clk);
    spe <= 1'b0;
    wr_en <= 1'b0;
    rd(`GTM_A_CNT_LO, d); chk("write wins", 16'h5a, d);
    $display("count access test done");
    for (i = 0; i < 8; i++) begin
      wr(`GTM_A_CNT_LO, 8'h00);
      wr(`GTM_A_CNT_HI, 8'h00);
      run <= 1'b1;
      wr(`GTM_A_CTRL, ctl[i]);
      wt(126);
      wr(`GTM_A_CTRL, 8'h00);
      run <= 1'b0;
      rd(`GTM_A_CNT_LO, d); span("rate", expc[i], d);
    end
    $display("rate test done");
    wr(`GTM_A_CNT_HI, 8'hff);
    wr(`GTM_A_CNT_LO, 8'hf0);
    wr(`GTM_A_PIE, 8'h01);
    wr(`GTM_A_IRQ_CONTROL_REG, 8'hc0);
    wr(`GTM_A_CTRL, 8'h41);
    wt(40);
    rd(`GTM_A_PFLAG, d); chk("ovf flag", 16'h1, 16'(d[0]));
    chk("irq", 16'h1, 16'(irq));
    chk("vector", 16'h0004, vec);
    wr(`GTM_A_IRQ_CONTROL_REG, 8'h40);
    #1 chk("irq masked", 16'h0, 16'(irq));
    wr(`GTM_A_CTRL, 8'h00);
    rd(`GTM_A_CNT_HI, d); chk("rollover", 16'h0, d);
    slp <= 1'b1;
    wr(`GTM_A_CTRL, 8'h85);
    #1 chk("wake", 16'h1, 16'(wake));
    wr(`GTM_A_CTRL, 8'h00);
    slp <= 1'b0;
    wr(`GTM_A_PFLAG, 8'h00);
    wr(`GTM_A_IRQ_CONTROL_REG, 8'h00);
    $display("overflow test done");
    wr(`GTM_A_GATE, 8'hc0);
    wr(`GTM_A_CNT_LO, 8'h00);
    wr(`GTM_A_CTRL, 8'h41);
    wt(30);
    rd(`GTM_A_CNT_LO, d); chk("gate hold", 16'h0, d);
    pin_g <= 1'b1;
    wt(30);
    rd(`GTM_A_GATE, d); chk("gate level", 16'h1, 16'(d[2]));
    wr(`GTM_A_PFLAG, 8'h00);
    pin_g <= 1'b0;
    wt(3);
    rd(`GTM_A_PFLAG, d); chk("gate flag", 16'h1, 16'(d[7]));
    rd(`GTM_A_CNT_LO, d); span("gate count", 33, d);
    wr(`GTM_A_GATE, 8'h80);
    wr(`GTM_A_CNT_LO, 8'h00);
    wt(30);
    rd(`GTM_A_CNT_LO, d); span("low gate", 33, d);
    c2 <= 1'b1;
    wr(`GTM_A_GATE, 8'h43);
    wt(3);
    rd(`GTM_A_GATE, d); chk("src cmp2", 16'h1, 16'(d[2]));
    wr(`GTM_A_GATE, 8'h42);
    wt(3);
    rd(`GTM_A_GATE, d); chk("src cmp1", 16'h0, 16'(d[2]));
    wr(`GTM_A_GATE, 8'h60);
    pin_g <= 1'b1;
    wt(3);
    pin_g <= 1'b0;
    wt(3);
    rd(`GTM_A_GATE, d); chk("toggle", 16'h1, 16'(d[2]));
    wr(`GTM_A_CTRL, 8'h00);
    wt(2);
    rd(`GTM_A_GATE, d); chk("toggle off", 16'h0, 16'(d[2]));
    wr(`GTM_A_CTRL, 8'h41);
    wr(`GTM_A_GATE, 8'hd0);
    wr(`GTM_A_GATE, 8'hd8);
    rd(`GTM_A_GATE, d); chk("go armed", 16'h1, 16'(d[3]));
    pin_g <= 1'b1;
    wt(3);
    pin_g <= 1'b0;
    wt(3);
    rd(`GTM_A_GATE, d); chk("go done", 16'h0, 16'(d[3]));
    wr(`GTM_A_GATE, 8'hd8);
    wr(`GTM_A_GATE, 8'hc8);
    rd(`GTM_A_GATE, d); chk("go cleared", 16'h0, 16'(d[3]));
    $display("gate test done");
    wr(`GTM_A_CTRL, 8'h00);
    wr(`GTM_A_GATE, 8'h41);
    wr(`GTM_A_PFLAG, 8'h00);
    // The companion timer wraps every 256 cycles, so one pulse must land.
    wt(300);
    rd(`GTM_A_PFLAG, d);
    chk("wrap pulse", 16'h1, 16'(d[7]));
    wr(`GTM_A_CNT_HI, 8'h12);
    wr(`GTM_A_CNT_LO, 8'h34);
    @(posedge clk);
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    rd(`GTM_A_CCP_HI, d);
    chk("capture", 16'h12, d);
    wr(`GTM_A_CCP_HI, 8'h00);
    wr(`GTM_A_CCP_LO, 8'h20);
    wr(`GTM_A_CNT_HI, 8'h00);
    wr(`GTM_A_CNT_LO, 8'h00);
    wr(`GTM_A_CCP_CTRL, 8'h01);
    wr(`GTM_A_CTRL, 8'h41);
    wt(60);
    wr(`GTM_A_CTRL, 8'h00);
    chk("compare events", 16'h1, 16'(n_cmp));
    slp <= 1'b1;
    wr(`GTM_A_CNT_LO, 8'h00);
    wr(`GTM_A_CTRL, 8'h41);
    wt(20);
    rd(`GTM_A_CNT_LO, d);
    chk("sleep hold", 16'h0, d);
    wr(`GTM_A_CTRL, 8'h00);
    slp <= 1'b0;
    $display("capture test done");
    complete_run();
  end
endmodule
